/* File: hdl/host_port_pkg.sv */
// constants and types shared by the host serial port design
package host_port_pkg;
  localparam int         CLK_KHZ        = 10000;
  localparam int         I2C_FAST_KHZ   = 400;
  localparam int         I2C_HALF_CYC   = CLK_KHZ / (2 * I2C_FAST_KHZ);
  localparam logic [6:0] PAGE_OFFSET    = 7'h7f;
  localparam logic [6:0] CFG_OFFSET     = 7'h7e;
  localparam int         PAGE_BIT       = 0;
  localparam logic       PAGE_RESET     = 1'h0;
  localparam int         CFG_THREE_W    = 0;
  localparam int         CFG_SPI_MODE   = 1;
  localparam int         CFG_CPOL       = 2;
  localparam logic       THREE_W_RESET  = 1'h0;
  localparam logic [5:0] TARGET_ADDR_HI = 6'h1b;
  localparam logic [3:0] BIT_CNT_ZERO   = 4'h0;
  localparam logic [3:0] SPI_ADDR_LAST  = 4'h7;
  localparam logic [3:0] SPI_DATA_FIRST = 4'h8;
  localparam logic [3:0] SPI_BYTE_LAST  = 4'hf;
  localparam logic [3:0] I2C_BYTE_BITS  = 4'h8;
  localparam int         WORD_W         = 16;
  localparam int         FIFO_DEPTH     = 16;
  localparam int         MEM_WORDS      = 256;

  typedef enum logic [3:0] {
    I_IDLE, I_ADDR, I_ACK_ADDR, I_REG, I_ACK_REG,
    I_WDATA, I_ACK_W, I_RDATA, I_HACK
  } i2c_state_t;
endpackage : host_port_pkg

/* File: hdl/stream_if.sv */
// valid/ready word stream between design modules
`timescale 1ns/10ps
`default_nettype none
interface stream_if #(parameter int WIDTH = 16);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if
`default_nettype wire

/* File: hdl/word_fifo.sv */
// synchronous word fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  stream_if.snk    in_s,
  stream_if.src    out_s
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // depth must be a power of two so the pointers wrap by themselves
  assign in_s.ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_s.valid = (count_reg != '0);
  assign out_s.data  = store[rd_ptr_reg];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      store[wr_ptr_reg] <= in_s.data;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : word_fifo
`default_nettype wire

/* File: hdl/reg_array.sv */
// two-page register storage, two write ports and a registered read
`timescale 1ns/10ps
`default_nettype none
module reg_array (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       a_we,
  input  wire logic [7:0] a_addr,
  input  wire logic [7:0] a_wdata,
  input  wire logic       b_we,
  input  wire logic [7:0] b_addr,
  input  wire logic [7:0] b_wdata,
  input  wire logic [7:0] rd_addr,
  output var  logic [7:0] rd_data
);
  logic [7:0] cells [host_port_pkg::MEM_WORDS];

  // core port is written last so it wins a same-address collision
  always_ff @(posedge ref_clk) begin
    if (a_we) begin
      cells[a_addr] <= a_wdata;
    end
    if (b_we) begin
      cells[b_addr] <= b_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= cells[rd_addr];
    end
  end
endmodule : reg_array
`default_nettype wire

/* File: hdl/imu_host_serial_port.sv */
// host serial port: i2c or spi slave access to the register pages
// Behaviour
// [R1] port starts and stays i2c until select falls
// [R2] select falling edge switches port to spi
// [R3] spi modes 00/11 chosen from clock at select
// [R4] page register bit 0 picks register page
// [R5] first spi bit is read/write flag
// [R6] seven address bits then eight data bits
// [R7] spi burst auto-increments address while selected
// [R8] i2c address set by serial-out pin strap
// [R9] i2c slave works up to 400 kHz
// [R10] receiver holds data low through ack pulse
// [R11] host sends start, address, register index
// [R12] host repeated-starts then resends address for read
// [R13] device acks address, index, written data; stores data (a full write fifo nacks and drops the data byte)
// [R14] host acks each read byte wanting more
// [R15] read ends on host nack, write on stop
// [R16] i2c bytes travel msb first
// [R17] i2c bursts step register address per byte
// [R18] optional three-wire spi on shared data line
`timescale 1ns/10ps
`default_nettype none
module imu_host_serial_port (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        select_n_pin,
  input  wire logic        sclk_pin,
  input  wire logic        serial_in_pin_i,
  output logic             serial_in_pin_o,
  output logic             serial_in_pin_oe,
  input  wire logic        serial_out_pin_i,
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe,
  output logic             wr_valid,
  input  wire logic        wr_ready,
  output logic [15:0]      wr_word,
  input  wire logic        core_we,
  input  wire logic [7:0]  core_addr,
  input  wire logic [7:0]  core_wdata,
  output logic             spi_active
);
  logic [3:0]                  sync1_reg;
  logic [3:0]                  sync2_reg;
  logic [3:0]                  sync3_reg;
  logic                        cs;
  logic                        sck;
  logic                        din;
  logic                        strap;
  logic                        cs_fell;
  logic                        sck_rise;
  logic                        sck_fall;
  logic                        din_rise;
  logic                        din_fell;
  logic                        spi_mode_reg;
  logic                        spi_on;
  logic                        i2c_on;
  logic                        cpol_reg;
  logic                        spi_rw_reg;
  logic [3:0]                  spi_cnt_reg;
  logic                        so_bit_reg;
  logic [7:0]                  rx_shift_reg;
  logic [6:0]                  addr_reg;
  logic                        page_reg;
  logic                        three_wire_reg;
  host_port_pkg::i2c_state_t   i2c_st_reg;
  logic [3:0]                  i2c_cnt_reg;
  logic                        i2c_rw_reg;
  logic                        sda_low_reg;
  logic                        i2c_start;
  logic                        i2c_stop;
  logic                        addr_match;
  logic                        spi_wr;
  logic                        i2c_wr;
  logic                        wr_pulse;
  logic                        wr_accept;
  logic [7:0]                  wr_data;
  logic [7:0]                  mem_rdata;
  logic [7:0]                  rd_byte;
  logic [6:0]                  spi_addr_in;

  stream_if #(.WIDTH(host_port_pkg::WORD_W)) fill_s ();
  stream_if #(.WIDTH(host_port_pkg::WORD_W)) drain_s ();

  // every pin is foreign to ref_clk; levels come from the second stage, edges from it against the third
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= 4'hf;
      sync2_reg <= 4'hf;
      sync3_reg <= 4'hf;
    end else begin
      sync1_reg <= {select_n_pin, sclk_pin, serial_in_pin_i, serial_out_pin_i};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign cs       = sync2_reg[3];
  assign sck      = sync2_reg[2];
  assign din      = sync2_reg[1];
  assign strap    = sync2_reg[0];
  assign cs_fell  = sync3_reg[3] & ~cs;
  assign sck_rise = ~sync3_reg[2] & sck;
  assign sck_fall = sync3_reg[2] & ~sck;
  assign din_rise = ~sync3_reg[1] & din;
  assign din_fell = sync3_reg[1] & ~din;

  // sticky: there is no way back to i2c short of reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      spi_mode_reg <= 1'b0; // [R1]
    end else if (cs_fell) begin
      spi_mode_reg <= 1'b1; // [R2]
    end
  end

  assign spi_on     = spi_mode_reg & ~cs;
  assign i2c_on     = ~spi_mode_reg;
  assign spi_active = spi_mode_reg;

  // ---- spi framing
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cpol_reg    <= 1'b0;
      spi_rw_reg  <= 1'b0;
      spi_cnt_reg <= host_port_pkg::BIT_CNT_ZERO;
      so_bit_reg  <= 1'b0;
    end else if (cs_fell) begin
      cpol_reg    <= sck; // [R3]
      spi_cnt_reg <= host_port_pkg::BIT_CNT_ZERO;
    end else if (spi_on && sck_rise) begin
      // both modes sample on the rising edge, so only the idle level differs
      if (spi_cnt_reg == host_port_pkg::BIT_CNT_ZERO) begin
        spi_rw_reg <= din; // [R5]
      end
      if (spi_cnt_reg == host_port_pkg::SPI_BYTE_LAST) begin
        spi_cnt_reg <= host_port_pkg::SPI_DATA_FIRST; // [R7]
      end else begin
        spi_cnt_reg <= spi_cnt_reg + 4'h1;
      end
    end else if (spi_on && sck_fall && spi_cnt_reg[3]) begin
      so_bit_reg <= rd_byte[~spi_cnt_reg[2:0]]; // [R6]
    end
  end

  // shared receive shifter, msb first for both protocols
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_shift_reg <= 8'h00;
    end else if ((spi_on || i2c_on) && sck_rise) begin
      rx_shift_reg <= {rx_shift_reg[6:0], din}; // [R16]
    end
  end

  assign spi_addr_in = {rx_shift_reg[5:0], din};
  assign spi_wr      = spi_on & sck_rise & ~spi_rw_reg
                     & (spi_cnt_reg == host_port_pkg::SPI_BYTE_LAST);

  // ---- i2c slave
  assign i2c_start  = i2c_on & sck & din_fell;
  assign i2c_stop   = i2c_on & sck & din_rise;
  assign addr_match = (rx_shift_reg[7:1] == {host_port_pkg::TARGET_ADDR_HI, strap}); // [R8]
  assign i2c_wr     = i2c_on & sck_fall & (i2c_st_reg == host_port_pkg::I_WDATA)
                    & (i2c_cnt_reg == host_port_pkg::I2C_BYTE_BITS);

  // a full fifo makes the i2c write nack; spi cannot stall, so it drops
  assign wr_pulse  = spi_wr | i2c_wr;
  assign wr_accept = wr_pulse & fill_s.ready;
  assign wr_data   = spi_on ? {rx_shift_reg[6:0], din} : rx_shift_reg;

  // edges come through the synchroniser: 12 ref cycles per half period at
  // fast mode leaves margin, but a faster bus would break this
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      i2c_st_reg  <= host_port_pkg::I_IDLE;
      i2c_cnt_reg <= host_port_pkg::BIT_CNT_ZERO;
      i2c_rw_reg  <= 1'b0;
      sda_low_reg <= 1'b0;
    end else if (i2c_start) begin
      i2c_st_reg  <= host_port_pkg::I_ADDR; // [R9]
      i2c_cnt_reg <= host_port_pkg::BIT_CNT_ZERO;
      sda_low_reg <= 1'b0;
    end else if (i2c_stop) begin
      i2c_st_reg  <= host_port_pkg::I_IDLE; // [R15]
      sda_low_reg <= 1'b0;
    end else if (i2c_on && sck_rise) begin
      case (i2c_st_reg)
        host_port_pkg::I_ADDR, host_port_pkg::I_REG,
        host_port_pkg::I_WDATA, host_port_pkg::I_RDATA: begin
          i2c_cnt_reg <= i2c_cnt_reg + 4'h1;
        end
        host_port_pkg::I_HACK: begin
          if (din) begin
            i2c_st_reg <= host_port_pkg::I_IDLE; // [R15]
          end
        end
        default: begin
        end
      endcase
    end else if (i2c_on && sck_fall) begin
      case (i2c_st_reg)
        host_port_pkg::I_ADDR: begin
          if (i2c_cnt_reg == host_port_pkg::I2C_BYTE_BITS) begin
            if (addr_match) begin
              i2c_st_reg  <= host_port_pkg::I_ACK_ADDR;
              i2c_rw_reg  <= rx_shift_reg[0];
              sda_low_reg <= 1'b1; // [R13]
            end else begin
              i2c_st_reg <= host_port_pkg::I_IDLE;
            end
          end
        end
        host_port_pkg::I_ACK_ADDR: begin
          i2c_cnt_reg <= host_port_pkg::BIT_CNT_ZERO;
          if (i2c_rw_reg) begin
            i2c_st_reg  <= host_port_pkg::I_RDATA;
            sda_low_reg <= ~rd_byte[7]; // [R16]
          end else begin
            i2c_st_reg  <= host_port_pkg::I_REG;
            sda_low_reg <= 1'b0; // [R10]
          end
        end
        host_port_pkg::I_REG: begin
          if (i2c_cnt_reg == host_port_pkg::I2C_BYTE_BITS) begin
            i2c_st_reg  <= host_port_pkg::I_ACK_REG;
            sda_low_reg <= 1'b1; // [R13]
          end
        end
        host_port_pkg::I_WDATA: begin
          if (i2c_cnt_reg == host_port_pkg::I2C_BYTE_BITS) begin
            i2c_st_reg  <= fill_s.ready ? host_port_pkg::I_ACK_W : host_port_pkg::I_IDLE;
            sda_low_reg <= fill_s.ready; // [R13]
          end
        end
        host_port_pkg::I_ACK_REG, host_port_pkg::I_ACK_W: begin
          i2c_st_reg  <= host_port_pkg::I_WDATA;
          i2c_cnt_reg <= host_port_pkg::BIT_CNT_ZERO;
          sda_low_reg <= 1'b0; // [R10]
        end
        host_port_pkg::I_RDATA: begin
          if (i2c_cnt_reg == host_port_pkg::I2C_BYTE_BITS) begin
            i2c_st_reg  <= host_port_pkg::I_HACK;
            sda_low_reg <= 1'b0; // [R10]
          end else begin
            sda_low_reg <= ~rd_byte[~i2c_cnt_reg[2:0]]; // [R16]
          end
        end
        host_port_pkg::I_HACK: begin
          i2c_st_reg  <= host_port_pkg::I_RDATA; // [R14]
          i2c_cnt_reg <= host_port_pkg::BIT_CNT_ZERO;
          sda_low_reg <= ~rd_byte[7];
        end
        default: begin
          sda_low_reg <= 1'b0;
        end
      endcase
    end
  end

  // ---- register address pointer
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      addr_reg <= 7'h00;
    end else if (spi_on && sck_rise && spi_cnt_reg == host_port_pkg::SPI_ADDR_LAST) begin
      addr_reg <= spi_addr_in; // [R6]
    end else if (spi_on && sck_rise && spi_cnt_reg == host_port_pkg::SPI_BYTE_LAST) begin
      addr_reg <= addr_reg + 7'h01; // [R7]
    end else if (i2c_on && sck_fall && i2c_st_reg == host_port_pkg::I_REG
                 && i2c_cnt_reg == host_port_pkg::I2C_BYTE_BITS) begin
      addr_reg <= rx_shift_reg[6:0];
    end else if (i2c_on && sck_fall && i2c_st_reg == host_port_pkg::I_ACK_W) begin
      addr_reg <= addr_reg + 7'h01; // [R17]
    end else if (i2c_on && sck_rise && i2c_st_reg == host_port_pkg::I_HACK && !din) begin
      addr_reg <= addr_reg + 7'h01; // [R17]
    end
  end

  // ---- page and configuration registers, visible in both pages
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      page_reg       <= host_port_pkg::PAGE_RESET;
      three_wire_reg <= host_port_pkg::THREE_W_RESET;
    end else if (wr_accept && addr_reg == host_port_pkg::PAGE_OFFSET) begin
      page_reg <= wr_data[host_port_pkg::PAGE_BIT]; // [R4]
    end else if (wr_accept && addr_reg == host_port_pkg::CFG_OFFSET) begin
      three_wire_reg <= wr_data[host_port_pkg::CFG_THREE_W]; // [R18]
    end
  end

  always_comb begin
    rd_byte = mem_rdata;
    if (addr_reg == host_port_pkg::PAGE_OFFSET) begin
      rd_byte = {7'h00, page_reg};
    end else if (addr_reg == host_port_pkg::CFG_OFFSET) begin
      rd_byte = 8'h00;
      rd_byte[host_port_pkg::CFG_THREE_W] = three_wire_reg;
      rd_byte[host_port_pkg::CFG_SPI_MODE] = spi_mode_reg;
      rd_byte[host_port_pkg::CFG_CPOL] = cpol_reg;
    end
  end

  reg_array u_regs (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .a_we    (wr_accept),
    .a_addr  ({page_reg, addr_reg}), // [R4]
    .a_wdata (wr_data),
    .b_we    (core_we),
    .b_addr  (core_addr),
    .b_wdata (core_wdata),
    .rd_addr ({page_reg, addr_reg}),
    .rd_data (mem_rdata)
  );

  // every accepted write is also streamed to the core
  assign fill_s.valid  = wr_pulse; // [R13]
  assign fill_s.data   = {page_reg, addr_reg, wr_data};
  assign drain_s.ready = wr_ready;
  assign wr_valid      = drain_s.valid;
  assign wr_word       = drain_s.data;

  word_fifo #(.WIDTH(host_port_pkg::WORD_W), .DEPTH(host_port_pkg::FIFO_DEPTH)) u_fifo (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .in_s    (fill_s),
    .out_s   (drain_s)
  );

  // ---- pin drive
  assign serial_in_pin_o   = spi_mode_reg & so_bit_reg;
  assign serial_in_pin_oe  = spi_mode_reg ? (spi_on & three_wire_reg & spi_rw_reg & spi_cnt_reg[3])
                                          : sda_low_reg; // [R18]
  assign serial_out_pin_o  = so_bit_reg;
  assign serial_out_pin_oe = spi_on & ~three_wire_reg & spi_rw_reg & spi_cnt_reg[3]; // [R5]

  // ---- checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_i2c_stays: assert property (!spi_mode_reg && !cs_fell |=> !spi_mode_reg) // [R1]
    else $error("port left i2c without a select fall");
  a_spi_switch: assert property (cs_fell |=> spi_mode_reg ##1 spi_mode_reg) // [R2]
    else $error("select fall did not switch to spi");
  a_cpol_capture: assert property (cs_fell |=> cpol_reg == $past(sck)) // [R3]
    else $error("clock idle level not captured");
  a_page_write: assert property (wr_accept && addr_reg == host_port_pkg::PAGE_OFFSET
                                 |=> page_reg == $past(wr_data[0])) // [R4]
    else $error("page select not updated");
  a_spi_rwflag: assert property (spi_on && sck_rise && spi_cnt_reg == 4'h0
                                 && !cs_fell |=> spi_rw_reg == $past(din)) // [R5]
    else $error("direction flag not taken from first bit");
  a_spi_addr: assert property (spi_on && sck_rise && spi_cnt_reg == 4'h7 && !cs_fell
                               |=> addr_reg == $past(spi_addr_in) && spi_cnt_reg == 4'h8) // [R6]
    else $error("spi address not loaded after seven bits");
  a_spi_burst: assert property (spi_on && sck_rise && spi_cnt_reg == 4'hf && !cs_fell
                                |=> addr_reg == $past(addr_reg) + 7'h01
                                    && spi_cnt_reg == 4'h8) // [R7]
    else $error("burst address did not advance");
  a_addr_ack: assert property (i2c_on && !i2c_start && !i2c_stop && sck_fall
                               && i2c_st_reg == host_port_pkg::I_ADDR
                               && i2c_cnt_reg == 4'h8 && addr_match
                               |=> sda_low_reg && i2c_st_reg == host_port_pkg::I_ACK_ADDR) // [R8]
    else $error("matching target address not acknowledged");
  a_ack_high: assert property ((i2c_st_reg == host_port_pkg::I_ACK_REG
                                || i2c_st_reg == host_port_pkg::I_ACK_W) && sck_rise
                               |-> sda_low_reg ##1 sda_low_reg) // [R10]
    else $error("ack released during clock high");
  a_write_store: assert property (i2c_wr && fill_s.ready |=> i2c_st_reg == host_port_pkg::I_ACK_W
                                  && sda_low_reg) // [R13]
    else $error("accepted data byte not acknowledged");
  a_read_msb: assert property (i2c_on && !i2c_start && !i2c_stop && sck_fall && i2c_rw_reg
                               && i2c_st_reg == host_port_pkg::I_ACK_ADDR
                               |=> sda_low_reg == !$past(rd_byte[7])) // [R16]
    else $error("read byte not started with msb");
  a_nack_end: assert property (i2c_on && !i2c_start && !i2c_stop && sck_rise && din
                               && i2c_st_reg == host_port_pkg::I_HACK
                               |=> i2c_st_reg == host_port_pkg::I_IDLE && !sda_low_reg) // [R15]
    else $error("read continued after host nack");
endmodule : imu_host_serial_port
`default_nettype wire

/* File: test/host_link_model.sv */
// serial host model: i2c master and spi master on the port pins
`timescale 1ns/10ps
`default_nettype none
module host_link_model (
  output logic      scl,
  output logic      sel_n,
  output logic      sda_o,
  input  wire logic sda,
  input  wire logic miso
);
  initial begin
    scl   = 1'b1;
    sel_n = 1'b1;
    sda_o = 1'b1;
  end
  // 1400 ns halves keep the bus just under fast-mode speed
  task automatic i2c_bit(input logic b, output logic r);
    #700 sda_o = b;
    #700 scl = 1'b1;
    #700 r = sda;
    #700 scl = 1'b0;
  endtask : i2c_bit
  task automatic i2c_start();
    #700 sda_o = 1'b1;
    #700 scl = 1'b1;
    #700 sda_o = 1'b0;
    #700 scl = 1'b0;
  endtask : i2c_start
  task automatic i2c_stop();
    #700 sda_o = 1'b0;
    #700 scl = 1'b1;
    #700 sda_o = 1'b1;
  endtask : i2c_stop
  // msb first, then the line is released for the ack pulse
  task automatic i2c_byte(input logic [7:0] b, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) i2c_bit(b[i], r);
    i2c_bit(1'b1, ack_n);
  endtask : i2c_byte
  task automatic i2c_rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) i2c_bit(1'b1, d[i]);
    i2c_bit(last, r);
  endtask : i2c_rd
  task automatic spi_begin(input logic cpol);
    // a clock move in the step of a stop would hide the stop from the port
    #400 scl = cpol;
    #400 sel_n = 1'b0;
    #400;
  endtask : spi_begin
  // sampled late in the high phase, where the device's bit has settled
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      scl = 1'b0;
      sda_o = tx[i];
      #400 scl = 1'b1;
      #400 rx[i] = miso;
    end
  endtask : spi_byte
  task automatic spi_end(input logic cpol);
    scl = cpol;
    #400 sel_n = 1'b1;
    sda_o = 1'b1;
    #800;
  endtask : spi_end
endmodule : host_link_model
`default_nettype wire

/* File: test/imu_host_serial_port_tb.sv */
// testbench: i2c and spi host traffic against the host serial port
`timescale 1ns/10ps
`default_nettype none
module imu_host_serial_port_tb;
  logic        ref_clk;
  logic        nrst;
  logic        strap;
  logic        wr_ready;
  logic        core_we;
  logic [7:0]  core_addr;
  logic [7:0]  core_wdata;
  logic        scl, sel_n, host_sda, sda, miso;
  logic        in_o, in_oe, out_o, out_oe, wr_valid, spi_active, ack_n;
  logic [15:0] wr_word;
  logic [7:0]  rx;
  int          miscompares = 0;
  int          compares = 0;
  int          cycles = 0;

  assign sda  = host_sda & ~(in_oe & ~in_o);
  // a released line toggles so stale data never matches; three-wire reads use the shared line
  assign miso = in_oe ? in_o : (out_oe ? out_o : ref_clk);

  imu_host_serial_port dut_u (
    .ref_clk (ref_clk), .nrst (nrst), .select_n_pin (sel_n), .sclk_pin (scl),
    .serial_in_pin_i (sda), .serial_in_pin_o (in_o), .serial_in_pin_oe (in_oe),
    .serial_out_pin_i (out_oe ? out_o : strap), .serial_out_pin_o (out_o),
    .serial_out_pin_oe (out_oe), .wr_valid (wr_valid), .wr_ready (wr_ready),
    .wr_word (wr_word), .core_we (core_we), .core_addr (core_addr),
    .core_wdata (core_wdata), .spi_active (spi_active));
  host_link_model host_u (.scl (scl), .sel_n (sel_n), .sda_o (host_sda), .sda (sda),
    .miso (miso));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic send(input logic [7:0] b, input logic exp_n);
    host_u.i2c_byte(b, ack_n);
    check("i2c ack", {15'h0, ack_n}, {15'h0, exp_n});
  endtask : send
  task automatic pop(input logic [15:0] exp);
    int n;
    n = 0;
    while (wr_valid !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check("fifo word", wr_word, exp);
    wr_ready = 1'b1;
    @(posedge ref_clk);
    #1 wr_ready = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : pop
  task automatic spi_wr(input logic [6:0] a, input logic [7:0] d, input int n);
    host_u.spi_begin(1'b0);
    host_u.spi_byte({1'b0, a}, rx);
    for (int k = 0; k < n; k++) host_u.spi_byte(d + 8'(k), rx);
    host_u.spi_end(1'b0);
  endtask : spi_wr
  task automatic spi_rd(input logic cpol, input logic [6:0] a, input logic [7:0] d, input int n);
    host_u.spi_begin(cpol);
    host_u.spi_byte({1'b1, a}, rx);
    for (int k = 0; k < n; k++) begin
      host_u.spi_byte(8'hff, rx);
      check("spi read", {8'h00, rx}, {8'h00, d + 8'(k)});
    end
    host_u.spi_end(cpol);
  endtask : spi_rd

  initial begin
    nrst = 1'b0;
    strap = 1'b0;
    wr_ready = 1'b0;
    core_we = 1'b0;
    core_addr = 8'h00;
    core_wdata = 8'h00;
    repeat (4) @(posedge ref_clk);
    #1 nrst = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1 check("idle outputs", {12'h0, spi_active, in_oe, out_oe, wr_valid}, 16'h0);
    host_u.i2c_start();
    send(8'h6c, 1'b0);
    send(8'h10, 1'b0);
    send(8'ha5, 1'b0);
    send(8'ha6, 1'b0);
    host_u.i2c_stop();
    pop(16'h10a5);
    pop(16'h11a6);
    strap = 1'b1;
    host_u.i2c_start();
    send(8'h6c, 1'b1);
    host_u.i2c_stop();
    host_u.i2c_start();
    send(8'h6e, 1'b0);
    send(8'h10, 1'b0);
    host_u.i2c_start();
    send(8'h6f, 1'b0);
    host_u.i2c_rd(1'b0, rx);
    check("i2c read", {8'h00, rx}, 16'h00a5);
    host_u.i2c_rd(1'b1, rx);
    check("i2c read", {8'h00, rx}, 16'h00a6);
    host_u.i2c_stop();
    // seventeen bytes into a stalled fifo: the last one is refused
    spi_wr(7'h40, 8'h00, 17);
    check("spi active", {15'h0, spi_active}, 16'h1);
    for (int k = 0; k < 16; k++) pop({1'b0, 7'(7'h40 + k), 8'(k)});
    repeat (5) @(posedge ref_clk);
    #1 check("fifo empty", {15'h0, wr_valid}, 16'h0);
    spi_rd(1'b1, 7'h10, 8'ha5, 2);
    core_we = 1'b1;
    core_addr = 8'h90;
    core_wdata = 8'h99;
    @(posedge ref_clk);
    #1 core_we = 1'b0;
    spi_wr(7'h7f, 8'h01, 1);
    pop(16'h7f01);
    spi_rd(1'b0, 7'h7f, 8'h01, 1);
    spi_rd(1'b0, 7'h10, 8'h99, 1);
    spi_wr(7'h20, 8'h77, 1);
    pop(16'ha077);
    spi_wr(7'h7e, 8'h01, 1);
    pop(16'hfe01);
    spi_rd(1'b1, 7'h7e, 8'h07, 1);
    summarize();
  end
endmodule : imu_host_serial_port_tb
`default_nettype wire
